/* File: core/mcu_isa_tail_executor.sv */
// How it works
// - Nibble exchange in place swaps bits 3..0 with 7..4 of the byte and writes it back.
// - Nibble exchange to accumulator puts the swapped byte in the accumulator only.
// - Skip when zero skips the next instruction if the byte is zero, changing nothing.
// - A taken skip adds one dummy cycle, so it costs two instruction cycles.
// - Copy then skip when zero loads the byte into the accumulator and skips if zero.
// - Skip when bit zero skips the next instruction if the selected bit is zero.
// - Current-page table read fetches the word at the high:low pointer into memory/latch.
// - Last-page table read fetches from the last page at the low pointer offset.
// - Exclusive-or to accumulator writes acc xor byte to the accumulator, zero flag only.
// - Exclusive-or to memory writes acc xor byte back to the byte, zero flag only.
// - Exclusive-or immediate writes acc xor immediate to the accumulator, zero flag only.
`include "tail_exec_regs.svh"
`default_nettype none
module mcu_isa_tail_executor (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // instruction from decoder, held for one cycle with i_valid
  input wire logic i_valid,
  input wire tail_exec_pkg::instr_t i_instr,
  // data memory read value for i_instr.addr, same cycle
  input wire logic [`DATA_W-1:0] i_mem_rdata,
  // table pointers
  input wire logic [`DATA_W-1:0] i_table_pointer_low,
  input wire logic [`DATA_W-1:0] i_table_pointer_high,
  // program code memory, word read back in the same cycle that o_code_rd is high
  output logic o_code_rd,
  output logic [`CODE_ADDR_W-1:0] o_code_addr,
  input wire logic [`CODE_W-1:0] i_code_rdata,
  // results
  output tail_exec_pkg::mem_wr_t o_mem_wr,
  output logic [`DATA_W-1:0] o_accumulator,
  output logic [`DATA_W-1:0] o_table_high_latch,
  output logic o_zero_flag_we,
  output logic o_zero_flag,
  // sequencing to the fetch logic
  output logic o_ready,
  output logic o_skip,
  output logic o_done
);
  tail_exec_pkg::state_t state_reg;
  tail_exec_pkg::state_t state_next;
  logic [`ADDR_W-1:0] tbl_addr_reg;
  logic [`DATA_W-1:0] acc_reg;
  logic [`DATA_W-1:0] xor_val;
  logic is_zero;
  logic take_skip;
  logic go;

  // nibble exchange used by both swap forms
  function automatic logic [`DATA_W-1:0] swap_nib(input logic [`DATA_W-1:0] v);
    swap_nib = {v[3:0], v[7:4]};
  endfunction

  assign go = i_valid && (state_reg == tail_exec_pkg::ST_IDLE);
  assign o_ready = (state_reg == tail_exec_pkg::ST_IDLE);
  assign is_zero = (i_mem_rdata == `ZERO_BYTE);
  // exclusive-or operand: immediate for the immediate form, else the byte
  assign xor_val = acc_reg ^ ((i_instr.op == tail_exec_pkg::OP_EXCLUSIVE_OR_IMMEDIATE) ?
                              i_instr.imm : i_mem_rdata);

  // skip decision for the three conditional forms
  always_comb begin
    take_skip = 1'b0;
    if (go) begin
      unique case (i_instr.op)
        tail_exec_pkg::OP_SKIP_WHEN_ZERO: take_skip = is_zero;
        tail_exec_pkg::OP_COPY_THEN_SKIP_WHEN_ZERO: take_skip = is_zero;
        tail_exec_pkg::OP_SKIP_WHEN_BIT_ZERO: take_skip = ~i_mem_rdata[i_instr.bit_sel];
        default: take_skip = 1'b0;
      endcase
    end
  end

  // sequencer: table reads wait for code memory, taken skips add a dummy cycle
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      tail_exec_pkg::ST_IDLE: begin
        if (go && (i_instr.op == tail_exec_pkg::OP_TABLE_READ_CURRENT_PAGE ||
                   i_instr.op == tail_exec_pkg::OP_TABLE_READ_LAST_PAGE)) begin
          state_next = tail_exec_pkg::ST_CODE_WAIT;
        end else if (take_skip) begin
          state_next = tail_exec_pkg::ST_DUMMY;
        end
      end
      tail_exec_pkg::ST_CODE_WAIT: state_next = tail_exec_pkg::ST_IDLE;
      tail_exec_pkg::ST_DUMMY: state_next = tail_exec_pkg::ST_IDLE;
      default: state_next = tail_exec_pkg::ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= tail_exec_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // program code address: current page uses both pointers, last page fixes the page
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_code_rd <= 1'b0;
      o_code_addr <= '0;
      tbl_addr_reg <= '0;
    end else begin
      o_code_rd <= 1'b0;
      if (go && i_instr.op == tail_exec_pkg::OP_TABLE_READ_CURRENT_PAGE) begin
        o_code_rd <= 1'b1;
        o_code_addr <= {i_table_pointer_high[3:0], i_table_pointer_low};
        tbl_addr_reg <= i_instr.addr;
      end else if (go && i_instr.op == tail_exec_pkg::OP_TABLE_READ_LAST_PAGE) begin
        o_code_rd <= 1'b1;
        o_code_addr <= {`LAST_PAGE, i_table_pointer_low};
        tbl_addr_reg <= i_instr.addr;
      end
    end
  end

  // accumulator and zero flag
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_reg <= `ACC_RESET;
      o_zero_flag_we <= 1'b0;
      o_zero_flag <= 1'b0;
    end else begin
      o_zero_flag_we <= 1'b0;
      if (go) begin
        unique case (i_instr.op)
          tail_exec_pkg::OP_NIBBLE_EXCHANGE_TO_ACC: acc_reg <= swap_nib(i_mem_rdata);
          tail_exec_pkg::OP_COPY_THEN_SKIP_WHEN_ZERO: acc_reg <= i_mem_rdata;
          tail_exec_pkg::OP_EXCLUSIVE_OR_TO_ACC,
          tail_exec_pkg::OP_EXCLUSIVE_OR_IMMEDIATE: begin
            acc_reg <= xor_val;
            o_zero_flag_we <= 1'b1;
            o_zero_flag <= (xor_val == `ZERO_BYTE);
          end
          tail_exec_pkg::OP_EXCLUSIVE_OR_TO_MEMORY: begin
            o_zero_flag_we <= 1'b1;
            o_zero_flag <= (xor_val == `ZERO_BYTE);
          end
          default: acc_reg <= acc_reg;
        endcase
      end
    end
  end
  assign o_accumulator = acc_reg;

  // data memory writes and table-high latch
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mem_wr <= '0;
      o_table_high_latch <= `LATCH_RESET;
    end else begin
      o_mem_wr.en <= 1'b0;
      if (state_reg == tail_exec_pkg::ST_CODE_WAIT) begin
        o_mem_wr <= {1'b1, tbl_addr_reg, i_code_rdata[7:0]};
        o_table_high_latch <= i_code_rdata[15:8];
      end else if (go && i_instr.op == tail_exec_pkg::OP_NIBBLE_EXCHANGE) begin
        o_mem_wr <= {1'b1, i_instr.addr, swap_nib(i_mem_rdata)};
      end else if (go && i_instr.op == tail_exec_pkg::OP_EXCLUSIVE_OR_TO_MEMORY) begin
        o_mem_wr <= {1'b1, i_instr.addr, xor_val};
      end
    end
  end

  // completion and skip report to the fetch logic
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_skip <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_skip <= take_skip;
      // untaken skips and plain ops finish in the cycle after issue
      o_done <= (go && !take_skip && state_next == tail_exec_pkg::ST_IDLE) ||
                (state_reg != tail_exec_pkg::ST_IDLE);
    end
  end

  // a taken skip is followed by exactly one dummy cycle
  sequence s_skip_issue;
    go && take_skip;
  endsequence
  property p_skip_dummy;
    @(posedge i_clock) disable iff (!i_rst_n)
      s_skip_issue |=> (state_reg == tail_exec_pkg::ST_DUMMY) && o_skip ##1 o_ready;
  endproperty
  a_skip_dummy: assert property (p_skip_dummy) else $error("skip dummy cycle wrong");

  // untaken skip when zero completes next cycle without delay
  property p_no_skip;
    @(posedge i_clock) disable iff (!i_rst_n)
      (go && !take_skip && i_instr.op == tail_exec_pkg::OP_SKIP_WHEN_ZERO) |=> o_done && o_ready;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("untaken skip stalled");

  // zero byte test skips
  property p_zero_skip;
    @(posedge i_clock) disable iff (!i_rst_n)
      (go && i_instr.op == tail_exec_pkg::OP_SKIP_WHEN_ZERO) |=> o_skip == $past(is_zero);
  endproperty
  a_zero_skip: assert property (p_zero_skip) else $error("zero skip wrong");

  // bit test skip
  property p_bit_skip;
    @(posedge i_clock) disable iff (!i_rst_n)
      (go && i_instr.op == tail_exec_pkg::OP_SKIP_WHEN_BIT_ZERO)
        |=> o_skip == !$past(i_mem_rdata[i_instr.bit_sel]) && !o_mem_wr.en;
  endproperty
  a_bit_skip: assert property (p_bit_skip) else $error("bit skip wrong");

  // swap in place writes the swapped byte
  property p_swap_mem;
    @(posedge i_clock) disable iff (!i_rst_n)
      (go && i_instr.op == tail_exec_pkg::OP_NIBBLE_EXCHANGE)
        |=> o_mem_wr.en && o_mem_wr.data == {$past(i_mem_rdata[3:0]), $past(i_mem_rdata[7:4])};
  endproperty
  a_swap_mem: assert property (p_swap_mem) else $error("swap write wrong");

  // swap to accumulator leaves memory alone
  property p_swap_acc;
    @(posedge i_clock) disable iff (!i_rst_n)
      (go && i_instr.op == tail_exec_pkg::OP_NIBBLE_EXCHANGE_TO_ACC)
        |=> !o_mem_wr.en && o_accumulator == {$past(i_mem_rdata[3:0]), $past(i_mem_rdata[7:4])};
  endproperty
  a_swap_acc: assert property (p_swap_acc) else $error("swap to acc wrong");

  // copy then skip loads accumulator
  property p_copy_skip;
    @(posedge i_clock) disable iff (!i_rst_n)
      (go && i_instr.op == tail_exec_pkg::OP_COPY_THEN_SKIP_WHEN_ZERO)
        |=> o_accumulator == $past(i_mem_rdata) && o_skip == (o_accumulator == `ZERO_BYTE);
  endproperty
  a_copy_skip: assert property (p_copy_skip) else $error("copy skip wrong");

  // table read lands two cycles after issue
  sequence s_table_issue;
    go && (i_instr.op == tail_exec_pkg::OP_TABLE_READ_CURRENT_PAGE ||
           i_instr.op == tail_exec_pkg::OP_TABLE_READ_LAST_PAGE);
  endsequence
  property p_table;
    @(posedge i_clock) disable iff (!i_rst_n)
      s_table_issue |=> o_code_rd ##1 o_mem_wr.en && o_table_high_latch == $past(i_code_rdata[15:8]);
  endproperty
  a_table: assert property (p_table) else $error("table read wrong");

  // last page read addresses the last page
  property p_last_page;
    @(posedge i_clock) disable iff (!i_rst_n)
      (go && i_instr.op == tail_exec_pkg::OP_TABLE_READ_LAST_PAGE)
        |=> o_code_addr == {`LAST_PAGE, $past(i_table_pointer_low)};
  endproperty
  a_last_page: assert property (p_last_page) else $error("last page address wrong");

  // exclusive-or to accumulator and immediate forms set the zero flag from their result
  property p_xor_zero;
    @(posedge i_clock) disable iff (!i_rst_n)
      (go && (i_instr.op == tail_exec_pkg::OP_EXCLUSIVE_OR_TO_ACC ||
              i_instr.op == tail_exec_pkg::OP_EXCLUSIVE_OR_IMMEDIATE))
        |=> o_zero_flag_we && o_zero_flag == (o_accumulator == `ZERO_BYTE);
  endproperty
  a_xor_zero: assert property (p_xor_zero) else $error("xor zero flag wrong");

  // exclusive-or to memory writes back, accumulator unchanged
  property p_xor_mem;
    @(posedge i_clock) disable iff (!i_rst_n)
      (go && i_instr.op == tail_exec_pkg::OP_EXCLUSIVE_OR_TO_MEMORY)
        |=> o_mem_wr.en && $stable(o_accumulator) && o_zero_flag == (o_mem_wr.data == `ZERO_BYTE);
  endproperty
  a_xor_mem: assert property (p_xor_mem) else $error("xor to memory wrong");

  // immediate form uses the immediate operand
  property p_xor_imm;
    @(posedge i_clock) disable iff (!i_rst_n)
      (go && i_instr.op == tail_exec_pkg::OP_EXCLUSIVE_OR_IMMEDIATE)
        |=> o_accumulator == ($past(acc_reg) ^ $past(i_instr.imm));
  endproperty
  a_xor_imm: assert property (p_xor_imm) else $error("xor immediate wrong");
endmodule
`default_nettype wire

/* File: core/tail_exec_pkg.sv */
`default_nettype none
package tail_exec_pkg;
  // operation codes handed over by the core's decoder
  typedef enum logic [3:0] {
    OP_NONE = 4'b0000,
    OP_NIBBLE_EXCHANGE = 4'b0001,
    OP_NIBBLE_EXCHANGE_TO_ACC = 4'b0010,
    OP_SKIP_WHEN_ZERO = 4'b0011,
    OP_COPY_THEN_SKIP_WHEN_ZERO = 4'b0100,
    OP_SKIP_WHEN_BIT_ZERO = 4'b0101,
    OP_TABLE_READ_CURRENT_PAGE = 4'b0110,
    OP_TABLE_READ_LAST_PAGE = 4'b0111,
    OP_EXCLUSIVE_OR_TO_ACC = 4'b1000,
    OP_EXCLUSIVE_OR_TO_MEMORY = 4'b1001,
    OP_EXCLUSIVE_OR_IMMEDIATE = 4'b1010
  } op_t;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CODE_WAIT = 2'b01,
    ST_DUMMY = 2'b10
  } state_t;

  // one instruction request from the decoder
  typedef struct packed {
    op_t op;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] imm;
  } instr_t;

  // data memory write carrier
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } mem_wr_t;
endpackage
`default_nettype wire

/* File: core/tail_exec_regs.svh */
`ifndef TAIL_EXEC_REGS_SVH
`define TAIL_EXEC_REGS_SVH
// data byte width and program word width
`define DATA_W 8
`define ADDR_W 8
`define CODE_W 16
`define CODE_ADDR_W 12
// last program page number used by the last-page table read
`define LAST_PAGE 4'hf
// reset values and the zero byte used for compares
`define ACC_RESET 8'h00
`define LATCH_RESET 8'h00
`define ZERO_BYTE 8'h00
`endif

/* File: tb/tail_exec_mem_model.sv */
`default_nettype none
module tail_exec_mem_model (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // data memory side
  input wire logic [7:0] i_addr,
  input wire tail_exec_pkg::mem_wr_t i_mem_wr,
  output logic [7:0] o_rdata,
  // program memory side
  input wire logic i_code_rd,
  input wire logic [11:0] i_code_addr,
  output logic [15:0] o_code_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  // data ram answers in the same cycle as the address
  assign o_rdata = mem[i_addr];
  // writes land on the edge that ends the pulse; the bench preloads bytes directly
  always @(posedge i_clock) begin
    if (i_mem_wr.en === 1'b1) begin
      mem[i_mem_wr.addr] <= i_mem_wr.data;
    end
  end
  logic [15:0] code_word;
  // the design registers the address, so the word must stand while the request is high
  assign code_word = {i_code_addr[11:4] ^ 8'ha5, i_code_addr[7:0] ^ 8'h3c};
  // outside a request the inverse shows, so a sample in the wrong cycle cannot pass
  assign o_code_rdata = (i_code_rd === 1'b1 && i_rst_n === 1'b1) ? code_word : ~code_word;
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_valid = 1'b0;
  tail_exec_pkg::instr_t i_instr = '0;
  logic [7:0] tpl = 8'h00;
  logic [7:0] tph = 8'h00;
  logic [7:0] mem_rdata;
  logic [15:0] code_rdata;
  logic [11:0] code_addr;
  logic code_rd, zwe, zf, ready, skip, done;
  tail_exec_pkg::mem_wr_t mem_wr;
  logic [7:0] acc, latch;
  logic s_skip, s_ready, s_zwe, s_zf, s_done;
  logic [11:0] s_caddr;
  logic [7:0] zv [2] = '{8'h00, 8'h40};
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  // design and its far-side memories
  mcu_isa_tail_executor DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_valid(i_valid),
    .i_instr(i_instr), .i_mem_rdata(mem_rdata), .i_table_pointer_low(tpl),
    .i_table_pointer_high(tph), .o_code_rd(code_rd), .o_code_addr(code_addr),
    .i_code_rdata(code_rdata), .o_mem_wr(mem_wr), .o_accumulator(acc),
    .o_table_high_latch(latch), .o_zero_flag_we(zwe), .o_zero_flag(zf),
    .o_ready(ready), .o_skip(skip), .o_done(done));
  tail_exec_mem_model u_mem (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_instr.addr),
    .i_mem_wr(mem_wr), .o_rdata(mem_rdata), .i_code_rd(code_rd),
    .i_code_addr(code_addr), .o_code_rdata(code_rdata));
  always #4 i_clock = ~i_clock;
  task automatic print_verdict();
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one request; first-cycle answers are captured, then wait for the sequencer to go idle
  task automatic run(input tail_exec_pkg::op_t op, input logic [7:0] a,
      input logic [2:0] b, input logic [7:0] imm);
    int n;
    i_instr = '{op: op, addr: a, bit_sel: b, imm: imm};
    i_valid = 1'b1;
    @(posedge i_clock);
    #1;
    i_valid = 1'b0;
    s_skip = skip;
    s_ready = ready;
    s_zwe = zwe;
    s_zf = zf;
    s_done = done;
    s_caddr = code_rd === 1'b1 ? code_addr : 12'h000;
    n = 0;
    while (ready !== 1'b1 && n < 8) begin
      @(posedge i_clock);
      #1;
      if (code_rd === 1'b1) s_caddr = code_addr;
      n++;
    end
    @(posedge i_clock);
    #1;
  endtask
  // hang guard: the whole sequence needs about 62 cycles
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge i_clock);
    #1;
    i_rst_n = 1'b1;
    check(acc, 8'h00);
    u_mem.mem[8'h10] = 8'h3c;
    run(tail_exec_pkg::OP_NIBBLE_EXCHANGE, 8'h10, 3'h0, 8'h00);
    check(u_mem.mem[8'h10], 8'hc3);
    check(s_zwe, 1'b0);
    u_mem.mem[8'h11] = 8'h81;
    run(tail_exec_pkg::OP_NIBBLE_EXCHANGE_TO_ACC, 8'h11, 3'h0, 8'h00);
    check(acc, 8'h18);
    check(u_mem.mem[8'h11], 8'h81);
    // a zero byte must skip and stall one cycle, a non-zero one must not
    foreach (zv[i]) begin
      u_mem.mem[8'h21] = zv[i];
      run(tail_exec_pkg::OP_SKIP_WHEN_ZERO, 8'h21, 3'h0, 8'h00);
      check(s_skip, zv[i] == 8'h00);
      check(s_ready, zv[i] != 8'h00);
      check(s_done, zv[i] != 8'h00);
      check(u_mem.mem[8'h21], zv[i]);
      run(tail_exec_pkg::OP_COPY_THEN_SKIP_WHEN_ZERO, 8'h21, 3'h0, 8'h00);
      check(s_skip, zv[i] == 8'h00);
      check(acc, zv[i]);
      check(s_zwe, 1'b0);
    end
    // every bit position, with set and clear bits mixed
    u_mem.mem[8'h22] = 8'ha5;
    for (int b = 0; b < 8; b++) begin
      run(tail_exec_pkg::OP_SKIP_WHEN_BIT_ZERO, 8'h22, 3'(b), 8'h00);
      check(s_skip, !u_mem.mem[8'h22][b]);
      check(s_ready, u_mem.mem[8'h22][b]);
      check(s_zwe, 1'b0);
    end
    check(u_mem.mem[8'h22], 8'ha5);
    // upper bits of the high pointer lie outside the 12-bit code space
    tpl = 8'h34;
    tph = 8'hfb;
    run(tail_exec_pkg::OP_TABLE_READ_CURRENT_PAGE, 8'h30, 3'h0, 8'h00);
    check(s_caddr, 12'hb34);
    check(s_done, 1'b0);
    check(u_mem.mem[8'h30], 8'h08);
    check(latch, 8'h16);
    tpl = 8'h77;
    tph = 8'h02;
    run(tail_exec_pkg::OP_TABLE_READ_LAST_PAGE, 8'h31, 3'h0, 8'h00);
    check(s_caddr, 12'hf77);
    check(u_mem.mem[8'h31], 8'h4b);
    check(latch, 8'h52);
    check(acc, 8'h40);
    u_mem.mem[8'h40] = 8'h40;
    run(tail_exec_pkg::OP_EXCLUSIVE_OR_TO_ACC, 8'h40, 3'h0, 8'h00);
    check(acc, 8'h00);
    check({s_zwe, s_zf}, 2'b11);
    run(tail_exec_pkg::OP_EXCLUSIVE_OR_IMMEDIATE, 8'h00, 3'h0, 8'h5a);
    check(acc, 8'h5a);
    check({s_zwe, s_zf}, 2'b10);
    u_mem.mem[8'h41] = 8'h5a;
    run(tail_exec_pkg::OP_EXCLUSIVE_OR_TO_MEMORY, 8'h41, 3'h0, 8'h00);
    check(u_mem.mem[8'h41], 8'h00);
    check(acc, 8'h5a);
    check({s_zwe, s_zf}, 2'b11);
    print_verdict();
  end
endmodule
`default_nettype wire
